// ==== hw/display_value_pkg.sv ====
`default_nettype none
// Overview of operation
// - Upper word held; lower write updates display.
// - Range -999..9999 or -99999..999999 by width.
// - Value type selects signedness and width.
// - Mode 00h: digits, overflow shown when out.
// - Mode 80h high message, 40h low message.
// - Minimum digit count, padded with leading zeros.
// - Bit 3 forces decimal point rightmost when digits are shown.
// - Low three bits place the decimal point.
// - Shift register moves value left by digits.
// - Four encodings; 16-bit ones ignore upper word.
// - Write protect never blocks these registers.
package display_value_pkg;

    // ****************************************************************
    // Register map and fields
    // ****************************************************************
    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 16;
    localparam logic [15:0] ADDR_VALUE_HIGH = 16'h0001;
    localparam logic [15:0] ADDR_VALUE_LOW  = 16'h0002;
    localparam logic [15:0] ADDR_MODE_FMT   = 16'h0003;
    localparam logic [15:0] ADDR_LEFT_SHIFT = 16'h0004;
    localparam logic [15:0] RESET_WORD      = 16'h0000;

    localparam logic [7:0]  MODE_NUMERIC    = 8'h00;
    localparam logic [7:0]  MODE_FIXED_HIGH = 8'h80;
    localparam logic [7:0]  MODE_FIXED_LOW  = 8'h40;
    localparam int          FMT_W           = 7;
    localparam int          MIN_DIGITS_LSB  = 4;
    localparam int          DP_FORCE_BIT    = 3;
    localparam int          DP_POS_LSB      = 0;
    localparam int          FIELD3_W        = 3;
    localparam int          SHIFT_W         = 4;

    // Value type encodings, in the order of the follower settings menu.
    localparam logic [1:0]  VT_U16          = 2'h0;
    localparam logic [1:0]  VT_S16          = 2'h1;
    localparam logic [1:0]  VT_U32          = 2'h2;
    localparam logic [1:0]  VT_S32          = 2'h3;

    // ****************************************************************
    // Symbol codes driven per digit position
    // ****************************************************************
    localparam int          SYM_W           = 5;
    localparam logic [4:0]  SYM_MINUS       = 5'h0A;
    localparam logic [4:0]  SYM_H           = 5'h0B;
    localparam logic [4:0]  SYM_I           = 5'h0C;
    localparam logic [4:0]  SYM_L           = 5'h0D;
    localparam logic [4:0]  SYM_O           = 5'h0E;
    localparam logic [4:0]  SYM_V           = 5'h0F;
    localparam logic [4:0]  SYM_BLANK       = 5'h1F;

    localparam int          MAG_W           = 20;
    localparam int          BCD_DIGITS      = 6;

endpackage
`default_nettype wire

// ==== hw/display_value_registers.sv ====
`timescale 1ns/1ps
`default_nettype none
module display_value_registers
    import display_value_pkg::*;
#(
    parameter int DIGITS = 4
)
(
    input  wire logic                     clock_i,
    input  wire logic                     rst_i,
    input  wire logic                     wr_en_i,
    input  wire logic                     rd_en_i,
    input  wire logic [ADDR_W-1:0]        addr_i,
    input  wire logic [DATA_W-1:0]        wr_data_i,
    input  wire logic [1:0]               value_type_i,
    output var  logic [DATA_W-1:0]        rd_data_o,
    output var  logic                     rd_valid_o,
    output var  logic [DIGITS*SYM_W-1:0]  symbols_o,
    output var  logic [DIGITS-1:0]        dp_o
);

    localparam logic signed [32:0] MAX_VAL = 33'(10**DIGITS - 1);
    localparam logic signed [32:0] MIN_VAL = -33'(10**(DIGITS-1) - 1);

    // ****************************************************************
    // Register group
    // ****************************************************************
    logic [DATA_W-1:0]   high_reg, high_next;
    logic [DATA_W-1:0]   low_reg, low_next;
    logic [7:0]          mode_reg, mode_next;
    logic [FMT_W-1:0]    fmt_reg, fmt_next;
    logic [SHIFT_W-1:0]  shift_reg, shift_next;
    logic signed [32:0]  shown_reg, shown_next;
    logic [DATA_W-1:0]   rd_data_next;
    logic                rd_valid_next;

    // The write-protect setting only guards configuration registers, so
    // these four addresses have no permit input at all.
    always_comb
    begin
        high_next     = high_reg;
        low_next      = low_reg;
        mode_next     = mode_reg;
        fmt_next      = fmt_reg;
        shift_next    = shift_reg;
        shown_next    = shown_reg;
        rd_data_next  = RESET_WORD;
        rd_valid_next = rd_en_i;
        if (wr_en_i)
        begin
            case (addr_i)
                ADDR_VALUE_HIGH: high_next = wr_data_i;
                ADDR_VALUE_LOW:
                begin
                    low_next = wr_data_i;
                    // Only the lower word commits, so a lone upper write never changes the digits.
                    case (value_type_i)
                        VT_U16:  shown_next = {17'h00000, wr_data_i};
                        VT_S16:  shown_next = {{17{wr_data_i[15]}}, wr_data_i};
                        VT_U32:  shown_next = {1'b0, high_reg, wr_data_i};
                        default: shown_next = {high_reg[15], high_reg, wr_data_i};
                    endcase
                end
                ADDR_MODE_FMT:
                begin
                    mode_next = wr_data_i[15:8];
                    fmt_next  = wr_data_i[FMT_W-1:0];
                end
                ADDR_LEFT_SHIFT: shift_next = wr_data_i[SHIFT_W-1:0];
                default: ;
            endcase
        end
        if (rd_en_i)
        begin
            case (addr_i)
                ADDR_VALUE_HIGH: rd_data_next = high_reg;
                ADDR_VALUE_LOW:  rd_data_next = low_reg;
                ADDR_MODE_FMT:   rd_data_next = {mode_reg, 1'b0, fmt_reg};
                ADDR_LEFT_SHIFT: rd_data_next = {12'h000, shift_reg};
                default:         rd_data_next = RESET_WORD;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            high_reg   <= RESET_WORD;
            low_reg    <= RESET_WORD;
            mode_reg   <= 8'h00;
            fmt_reg    <= 7'h00;
            shift_reg  <= 4'h0;
            shown_reg  <= 33'h000000000;
            rd_data_o  <= RESET_WORD;
            rd_valid_o <= 1'b0;
        end
        else
        begin
            high_reg   <= high_next;
            low_reg    <= low_next;
            mode_reg   <= mode_next;
            fmt_reg    <= fmt_next;
            shift_reg  <= shift_next;
            shown_reg  <= shown_next;
            rd_data_o  <= rd_data_next;
            rd_valid_o <= rd_valid_next;
        end
    end

    // ****************************************************************
    // Display group
    // ****************************************************************
    logic                       neg;
    logic signed [32:0]         abs_val;
    logic [MAG_W-1:0]           mag;
    logic [BCD_DIGITS*4-1:0]    bcd;
    logic [SYM_W-1:0]           raw [0:DIGITS-1];
    logic [DIGITS-1:0]          raw_dp;
    logic [DIGITS*SYM_W-1:0]    symbols_next;
    logic [DIGITS-1:0]          dp_next;
    logic [FIELD3_W-1:0]        min_digits;
    logic [FIELD3_W-1:0]        dp_pos;
    int                         len;

    always_comb
    begin
        neg          = shown_reg[32];
        abs_val      = neg ? -shown_reg : shown_reg;
        mag          = abs_val[MAG_W-1:0];
        min_digits   = fmt_reg[MIN_DIGITS_LSB +: FIELD3_W];
        dp_pos       = fmt_reg[DP_POS_LSB +: FIELD3_W];
        bcd          = '0;
        len          = 1;
        raw_dp       = '0;
        symbols_next = {DIGITS{SYM_BLANK}};
        dp_next      = '0;
        for (int d = 0; d < DIGITS; d++)
        begin
            raw[d] = SYM_BLANK;
        end
        for (int b = MAG_W - 1; b >= 0; b--)
        begin
            for (int d = 0; d < BCD_DIGITS; d++)
            begin
                if (bcd[d*4 +: 4] >= 4'h5)
                begin
                    bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'h3;
                end
            end
            bcd = {bcd[BCD_DIGITS*4-2:0], mag[b]};
        end
        for (int d = 0; d < DIGITS; d++)
        begin
            if (bcd[d*4 +: 4] != 4'h0)
            begin
                len = d + 1;
            end
        end
        if (int'(min_digits) + 1 > len)
        begin
            len = int'(min_digits) + 1;
        end
        // A fractional value still needs its units digit, as in 0.05.
        if (int'(dp_pos) + 1 > len)
        begin
            len = int'(dp_pos) + 1;
        end
        for (int d = 0; d < DIGITS; d++)
        begin
            if (d < len)
            begin
                raw[d] = {1'b0, bcd[d*4 +: 4]};
            end
            else if (neg && d == len)
            begin
                raw[d] = SYM_MINUS;
            end
        end
        // A position beyond the display simply shows no point.
        for (int d = 1; d < DIGITS; d++)
        begin
            if (int'(dp_pos) == d)
            begin
                raw_dp[d] = 1'b1;
            end
        end
        case (mode_reg)
            MODE_FIXED_HIGH:
            begin
                symbols_next[0 +: 4*SYM_W] = {SYM_MINUS, SYM_H, SYM_I, SYM_MINUS};
            end
            MODE_FIXED_LOW:
            begin
                symbols_next[0 +: 4*SYM_W] = {SYM_MINUS, SYM_L, SYM_O, SYM_MINUS};
            end
            default:
            begin
                if (shown_reg > MAX_VAL)
                begin
                    symbols_next[0 +: 3*SYM_W] = {SYM_O, SYM_V, SYM_H};
                end
                else if (shown_reg < MIN_VAL)
                begin
                    symbols_next[0 +: 3*SYM_W] = {SYM_O, SYM_V, SYM_L};
                end
                else
                begin
                    // Shifted-out digits are lost; vacated right positions go blank.
                    for (int d = 0; d < DIGITS; d++)
                    begin
                        if (d >= int'(shift_reg))
                        begin
                            symbols_next[d*SYM_W +: SYM_W] = raw[d - int'(shift_reg)];
                            dp_next[d] = raw_dp[d - int'(shift_reg)];
                        end
                    end
                    if (fmt_reg[DP_FORCE_BIT])
                    begin
                        dp_next = '0;
                        dp_next[0] = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            symbols_o <= {DIGITS{SYM_BLANK}};
            dp_o      <= '0;
        end
        else
        begin
            symbols_o <= symbols_next;
            dp_o      <= dp_next;
        end
    end

endmodule // display_value_registers
`default_nettype wire

// ==== dv/display_value_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module display_value_assertions
    import display_value_pkg::*;
#(
    parameter int DIGITS = 4
)
(
    input wire logic                    clock_i,
    input wire logic                    rst_i,
    input wire logic                    wr_en_i,
    input wire logic                    rd_en_i,
    input wire logic [ADDR_W-1:0]       addr_i,
    input wire logic [DATA_W-1:0]       wr_data_i,
    input wire logic [DATA_W-1:0]       rd_data_o,
    input wire logic                    rd_valid_o,
    input wire logic [DIGITS*SYM_W-1:0] symbols_o,
    input wire logic [DIGITS-1:0]       dp_o
);
    // ****************
    // Port checks
    // ****************
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    logic wr_mode;
    assign wr_mode = wr_en_i && addr_i == ADDR_MODE_FMT;
    // A mode write followed by a quiet cycle must show its effect two edges later.
    property msg_p(logic [7:0] m, logic [19:0] s);
        wr_mode && wr_data_i[15:8] == m ##1 !wr_en_i |=> symbols_o[19:0] == s && dp_o == '0;
    endproperty
    chk_read_answer: assert property (rd_en_i |=> rd_valid_o)
        else $error("read strobe not answered");
    chk_idle_read: assert property (!rd_en_i |=> !rd_valid_o && rd_data_o == 16'h0000)
        else $error("read data without read");
    chk_high_alone: assert property (wr_en_i && addr_i == ADDR_VALUE_HIGH && !$past(wr_en_i) && !$past(rst_i)
        ##1 !wr_en_i |=> $stable(symbols_o) && $stable(dp_o))
        else $error("upper word alone changed display");
    chk_fixed_high: assert property (msg_p(MODE_FIXED_HIGH, {SYM_MINUS, SYM_H, SYM_I, SYM_MINUS}))
        else $error("high message wrong");
    chk_fixed_low: assert property (msg_p(MODE_FIXED_LOW, {SYM_MINUS, SYM_L, SYM_O, SYM_MINUS}))
        else $error("low message wrong");
    chk_dp_forced: assert property (wr_mode && wr_data_i[3] && wr_data_i[15:14] == 2'h0 ##1 !wr_en_i
        |=> dp_o == DIGITS'(1) || symbols_o[4:0] inside {SYM_H, SYM_L})
        else $error("forced point not rightmost");
    chk_unmapped_read: assert property (rd_en_i && (addr_i == 16'h0000 || addr_i > ADDR_LEFT_SHIFT)
        |=> rd_data_o == 16'h0000)
        else $error("unmapped read not zero");
    chk_shift_reserved: assert property (rd_en_i && addr_i == ADDR_LEFT_SHIFT |=> rd_data_o[15:4] == 12'h000)
        else $error("shift reserved bits set");
    cover property (wr_en_i && addr_i == ADDR_VALUE_LOW);
    cover property (rd_valid_o);
    cover property (wr_mode && wr_data_i[15:8] == MODE_FIXED_LOW);
endmodule // display_value_assertions
bind display_value_registers display_value_assertions #(.DIGITS(DIGITS)) chk (.clock_i, .rst_i, .wr_en_i,
    .rd_en_i, .addr_i, .wr_data_i, .rd_data_o, .rd_valid_o, .symbols_o, .dp_o);
`default_nettype wire

// ==== dv/modbus_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model
    import display_value_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic [DATA_W-1:0] rd_data_i,
    input  wire logic              rd_valid_i,
    output var  logic              wr_en_o,
    output var  logic              rd_en_o,
    output var  logic [ADDR_W-1:0] addr_o,
    output var  logic [DATA_W-1:0] wr_data_o
);
    // ****************
    // Request tasks
    // ****************
    initial
    begin
        {wr_en_o, rd_en_o, addr_o, wr_data_o} = '0;
    end
    task automatic put(input logic [15:0] a, input logic [15:0] d);
        addr_o = a;
        wr_data_o = d;
        wr_en_o = 1'b1;
        @(posedge clock_i);
        #1;
    endtask
    // Released lines flip, so the block never profits from stale address or data.
    task automatic idle();
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o = ~addr_o;
        wr_data_o = ~wr_data_o;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clock_i);
        #1;
        put(a, d);
        idle();
    endtask
    task automatic wr32(input logic [15:0] hi, input logic [15:0] lo);
        @(posedge clock_i);
        #1;
        put(ADDR_VALUE_HIGH, hi);
        put(ADDR_VALUE_LOW, lo);
        idle();
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
        @(posedge clock_i);
        #1;
        addr_o = a;
        rd_en_o = 1'b1;
        @(posedge clock_i);
        #1;
        d = rd_data_i;
        ok = rd_valid_i;
        idle();
    endtask
endmodule // modbus_master_model
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench
    import display_value_pkg::*;
;
    localparam logic [4:0] B = SYM_BLANK;
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [1:0]  vt = VT_U16;
    logic        wr_en, rd_en, rvalid;
    logic [15:0] addr, wdata, rdata;
    logic [19:0] sym;
    logic [3:0]  dp;
    int          n_errors = 0;
    int          compares = 0;
    always #5 clock_i = ~clock_i;
    display_value_registers #(.DIGITS(4)) dut (.clock_i(clock_i), .rst_i(rst_i), .wr_en_i(wr_en),
        .rd_en_i(rd_en), .addr_i(addr), .wr_data_i(wdata), .value_type_i(vt), .rd_data_o(rdata),
        .rd_valid_o(rvalid), .symbols_o(sym), .dp_o(dp));
    modbus_master_model master (.clock_i(clock_i), .rd_data_i(rdata), .rd_valid_i(rvalid), .wr_en_o(wr_en),
        .rd_en_o(rd_en), .addr_o(addr), .wr_data_o(wdata));
    // ****************
    // Helpers
    // ****************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic show(input logic [19:0] es, input logic [3:0] ed);
        repeat (2) @(posedge clock_i);
        #1;
        check("symbols", sym, es);
        check("dp", dp, ed);
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic        ok;
        master.rd(a, d, ok);
        check("rd_valid", ok, 1);
        check("rd_data", d, e);
    endtask
    task automatic val(input logic [1:0] t, input logic [15:0] hi, input logic [15:0] lo, input logic [19:0] es);
        vt = t;
        master.wr32(hi, lo);
        show(es, 4'h0);
    endtask
    task automatic conclude();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        show({B, B, B, 5'h00}, 4'h0);
        for (int a = 1; a <= 4; a++)
            rdchk(16'(a), 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_values();
        val(VT_U32, 16'h0000, 16'h1234, {5'h04, 5'h06, 5'h06, 5'h00});
        master.wr(ADDR_VALUE_HIGH, 16'h0001);
        show({5'h04, 5'h06, 5'h06, 5'h00}, 4'h0);
        master.wr(ADDR_VALUE_LOW, 16'h0000);
        show({B, SYM_O, SYM_V, SYM_H}, 4'h0);
        val(VT_S32, 16'hFFFF, 16'hFC19, {SYM_MINUS, 5'h09, 5'h09, 5'h09});
        val(VT_S32, 16'hFFFF, 16'hFC18, {B, SYM_O, SYM_V, SYM_L});
        val(VT_U32, 16'h0000, 16'h270F, {5'h09, 5'h09, 5'h09, 5'h09});
        val(VT_S16, 16'h0001, 16'hFFFF, {B, B, SYM_MINUS, 5'h01});
        val(VT_U16, 16'h0001, 16'hFFFF, {B, SYM_O, SYM_V, SYM_H});
        $display("test values done");
    endtask
    task automatic t_format();
        vt = VT_U16;
        master.wr(ADDR_VALUE_LOW, 16'h0005);
        master.wr(ADDR_MODE_FMT, 16'h0021);
        show({B, 5'h00, 5'h00, 5'h05}, 4'h2);
        master.wr(ADDR_MODE_FMT, 16'h000A);
        show({B, 5'h00, 5'h00, 5'h05}, 4'h1);
        master.wr(ADDR_MODE_FMT, 16'h12FF);
        show({5'h00, 5'h00, 5'h00, 5'h05}, 4'h1);
        rdchk(ADDR_MODE_FMT, 16'h127F);
        $display("test format done");
    endtask
    task automatic t_shift_msgs();
        master.wr(ADDR_MODE_FMT, 16'h0001);
        master.wr(ADDR_LEFT_SHIFT, 16'hFFF1);
        show({B, 5'h00, 5'h05, B}, 4'h4);
        rdchk(ADDR_LEFT_SHIFT, 16'h0001);
        master.wr(ADDR_MODE_FMT, 16'h8001);
        show({SYM_MINUS, SYM_H, SYM_I, SYM_MINUS}, 4'h0);
        master.wr(ADDR_MODE_FMT, 16'h4001);
        show({SYM_MINUS, SYM_L, SYM_O, SYM_MINUS}, 4'h0);
        master.wr(16'h0005, 16'h1234);
        rdchk(16'h0005, 16'h0000);
        rdchk(16'h0000, 16'h0000);
        rdchk(ADDR_MODE_FMT, 16'h4001);
        $display("test shift and messages done");
    endtask
    // A reset in mid-run must drop the held upper word, format and shift.
    task automatic t_mid_reset();
        rst_i = 1'b1;
        repeat (2) @(posedge clock_i);
        #1;
        rst_i = 1'b0;
        show({B, B, B, 5'h00}, 4'h0);
        rdchk(ADDR_VALUE_HIGH, 16'h0000);
        rdchk(ADDR_MODE_FMT, 16'h0000);
        rdchk(ADDR_LEFT_SHIFT, 16'h0000);
        $display("test mid-run reset done");
    endtask
    initial
    begin
        repeat (5000) @(posedge clock_i);
        n_errors++;
        conclude();
    end
    initial
    begin
        repeat (16) @(posedge clock_i);
        #1;
        rst_i = 1'b0;
        t_reset();
        t_values();
        t_format();
        t_shift_msgs();
        t_mid_reset();
        conclude();
    end
endmodule // testbench
`default_nettype wire
